// >>> src/tpdmb_defines.vh
// Register indices, field positions and reset values of the debug bank
`ifndef TPDMB_DEFINES_VH
`define TPDMB_DEFINES_VH

// Register indices; byte address is four times the index
`define TPDMB_IDX_W 10
`define TPDMB_IDX_CPL 10'h1ac
`define TPDMB_IDX_TRC 10'h1ad
`define TPDMB_IDX_FSEL 10'h1c8
`define TPDMB_IDX_TOS 10'h1c9
`define TPDMB_IDX_DBG 10'h1d9
`define TPDMB_IDX_LSRC 10'h1dd
`define TPDMB_IDX_LDST 10'h1de
`define TPDMB_IDX_SMBASE 10'h1f2
`define TPDMB_IDX_SMMASK 10'h1f3
`define TPDMB_IDX_PWR 10'h1fc
`define TPDMB_IDX_MTB0 10'h200
`define TPDMB_IDX_MTM0 10'h201
`define TPDMB_IDX_MTB1 10'h202
`define TPDMB_IDX_MTM1 10'h203

// current_power_limits fields
`define TPDMB_PWR_LIM_LSB 0
`define TPDMB_PWR_LIM_MSB 14
`define TPDMB_PWR_OVR_BIT 15
`define TPDMB_CUR_LIM_LSB 16
`define TPDMB_CUR_LIM_MSB 30
`define TPDMB_CUR_OVR_BIT 31
`define TPDMB_CPL_MASK 32'hffffffff

// turbo_ratio_caps fields
`define TPDMB_R1_LSB 0
`define TPDMB_R2_LSB 8
`define TPDMB_R3_LSB 16
`define TPDMB_R4_LSB 24
`define TPDMB_TRC_WE_BIT 28

// Implemented bits of the control words
`define TPDMB_FSEL_MASK 32'h000003ff
`define TPDMB_DBG_MASK 32'h0000ffff
`define TPDMB_TOS_MASK 32'h0000000f
`define TPDMB_IDLE_LOW_BIT 1
`define TPDMB_PWR_MASK 32'h00000002

// Reset values
`define TPDMB_CPL_RST 32'h00000000
`define TPDMB_TRC_RST 32'h00000000
`define TPDMB_FSEL_RST 32'h00000000
`define TPDMB_DBG_RST 32'h00000000
`define TPDMB_PWR_RST 32'h00000000

`endif

// >>> src/tpdmb_bank.v
// Power, turbo ratio and branch debug register bank on AHB-Lite
`timescale 1ns/100ps
`include "tpdmb_defines.vh"

// Behaviour
// - Bits 30:16 of current_power_limits hold a writable current limit in eighth-amp units.
// - Bit 31 of current_power_limits is a writable current limit override flag, one meaning active.
// - turbo_ratio_caps ignores writes unless platform capability bit 28 is one.
// - turbo_ratio_caps holds the one-core ratio in bits 7:0 and the two-core ratio in bits 15:8.
// - turbo_ratio_caps holds the three-core ratio in bits 23:16 and the four-core ratio in bits 31:24.
// - branch_filter_select at index 1C8 is writable and steers which branch kinds are recorded.
// - branch_stack_top is read only and bits 3:0 index the newest recorded branch.
// - exception_branch_source captures the source of the last recorded (not filtered) branch before the latest exception.
// - exception_branch_target captures the target of that same branch.
// - With power_control bit 1 set, the minimum operating point is requested once all cores idle.
// - debug_control at index 1D9 is a writable control register.
// - Bits 14:0 of current_power_limits hold a writable power limit in eighth-watt units.
module tpdmb_bank #(
   parameter NCORES = 4,
   parameter ADDR_W = 32,
   parameter [31:0] TRC_RST = `TPDMB_TRC_RST
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire [31:0] platform_capability_reg,
   input wire branch_taken,
   input wire [3:0] branch_kind,
   input wire [ADDR_W-1:0] branch_from,
   input wire [ADDR_W-1:0] branch_to,
   input wire exception_event,
   input wire [NCORES-1:0] core_in_wait_idle,
   output reg [31:0] current_power_limits_r,
   output reg [31:0] turbo_ratio_caps_r,
   output reg [31:0] branch_filter_select_r,
   output reg [31:0] debug_control_r,
   output reg branch_recorded_r,
   output reg min_point_req_r
);

   reg wr_pend_r;
   reg [`TPDMB_IDX_W-1:0] wr_idx_r;
   reg [3:0] branch_stack_top_r;
   reg [ADDR_W-1:0] last_from_r;
   reg [ADDR_W-1:0] last_to_r;
   reg [ADDR_W-1:0] exception_branch_source_r;
   reg [ADDR_W-1:0] exception_branch_target_r;
   reg [31:0] power_control_r;

   reg [31:0] cpl_nxt;
   reg [31:0] trc_nxt;
   reg [31:0] fsel_nxt;
   reg [31:0] dbg_nxt;
   reg [31:0] pwr_nxt;
   reg [3:0] tos_nxt;
   reg [ADDR_W-1:0] lsrc_nxt;
   reg [ADDR_W-1:0] ldst_nxt;
   reg [31:0] hrdata_nxt;
   reg branch_keep;

   wire accept;
   wire [`TPDMB_IDX_W-1:0] addr_idx;

   assign accept = hsel & hready & htrans[1];
   assign addr_idx = haddr[`TPDMB_IDX_W+1:2];

   function wr_hit;
      input [`TPDMB_IDX_W-1:0] idx;
      begin
         wr_hit = wr_pend_r && (wr_idx_r == idx);
      end
   endfunction

   function [31:0] widen;
      input [ADDR_W-1:0] v;
      reg [63:0] tmp;
      begin
         tmp = 64'h0;
         tmp[ADDR_W-1:0] = v;
         widen = tmp[31:0];
      end
   endfunction

   // Filter select bit per branch kind decides whether it is kept
   always @* begin
      branch_keep = branch_taken &&
         !branch_filter_select_r[branch_kind];
   end

   // Next values, with the pending data-phase write applied
   always @* begin
      cpl_nxt = current_power_limits_r;
      trc_nxt = turbo_ratio_caps_r;
      fsel_nxt = branch_filter_select_r;
      dbg_nxt = debug_control_r;
      pwr_nxt = power_control_r;
      tos_nxt = branch_stack_top_r;
      lsrc_nxt = exception_branch_source_r;
      ldst_nxt = exception_branch_target_r;
      if (wr_hit(`TPDMB_IDX_CPL)) begin
         cpl_nxt = hwdata & `TPDMB_CPL_MASK;
      end
      if (wr_hit(`TPDMB_IDX_TRC) &&
          platform_capability_reg[`TPDMB_TRC_WE_BIT]) begin
         trc_nxt = hwdata;
      end
      if (wr_hit(`TPDMB_IDX_FSEL)) begin
         fsel_nxt = hwdata & `TPDMB_FSEL_MASK;
      end
      if (wr_hit(`TPDMB_IDX_DBG)) begin
         dbg_nxt = hwdata & `TPDMB_DBG_MASK;
      end
      if (wr_hit(`TPDMB_IDX_PWR)) begin
         pwr_nxt = hwdata & `TPDMB_PWR_MASK;
      end
      if (branch_keep) begin
         tos_nxt = branch_stack_top_r + 4'h1;
      end
      // Exception takes the branch recorded before this cycle
      if (exception_event) begin
         lsrc_nxt = last_from_r;
         ldst_nxt = last_to_r;
      end
   end

   // Read mux over next values so a read right after a write sees it
   always @* begin
      case (addr_idx)
         `TPDMB_IDX_CPL: hrdata_nxt = cpl_nxt;
         `TPDMB_IDX_TRC: hrdata_nxt = trc_nxt;
         `TPDMB_IDX_FSEL: hrdata_nxt = fsel_nxt;
         `TPDMB_IDX_TOS: hrdata_nxt = {28'h0, tos_nxt};
         `TPDMB_IDX_DBG: hrdata_nxt = dbg_nxt;
         `TPDMB_IDX_LSRC: hrdata_nxt = widen(lsrc_nxt);
         `TPDMB_IDX_LDST: hrdata_nxt = widen(ldst_nxt);
         `TPDMB_IDX_PWR: hrdata_nxt = pwr_nxt;
         default: hrdata_nxt = 32'h0;
      endcase
   end

   // Bus slave: zero wait states, always OKAY
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_idx_r <= {`TPDMB_IDX_W{1'b0}};
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= accept & hwrite;
         if (accept) begin
            wr_idx_r <= addr_idx;
         end
         if (accept && !hwrite) begin
            hrdata <= hrdata_nxt;
         end else begin
            hrdata <= 32'h0;
         end
      end
   end

   // Register state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         current_power_limits_r <= `TPDMB_CPL_RST;
         turbo_ratio_caps_r <= TRC_RST;
         branch_filter_select_r <= `TPDMB_FSEL_RST;
         debug_control_r <= `TPDMB_DBG_RST;
         power_control_r <= `TPDMB_PWR_RST;
         branch_stack_top_r <= 4'h0;
         last_from_r <= {ADDR_W{1'b0}};
         last_to_r <= {ADDR_W{1'b0}};
         exception_branch_source_r <= {ADDR_W{1'b0}};
         exception_branch_target_r <= {ADDR_W{1'b0}};
         branch_recorded_r <= 1'b0;
         min_point_req_r <= 1'b0;
      end else begin
         current_power_limits_r <= cpl_nxt;
         turbo_ratio_caps_r <= trc_nxt;
         branch_filter_select_r <= fsel_nxt;
         debug_control_r <= dbg_nxt;
         power_control_r <= pwr_nxt;
         branch_stack_top_r <= tos_nxt;
         exception_branch_source_r <= lsrc_nxt;
         exception_branch_target_r <= ldst_nxt;
         branch_recorded_r <= branch_keep;
         if (branch_keep) begin
            last_from_r <= branch_from;
            last_to_r <= branch_to;
         end
         // Minimum point only while enabled and every core idles
         min_point_req_r <= power_control_r[`TPDMB_IDLE_LOW_BIT] &
            (&core_in_wait_idle);
      end
   end

endmodule // tpdmb_bank

// >>> verif/tpdmb_bank_monitor.sv
// Port checker of the power and branch debug register bank
`timescale 1ns/100ps
`include "tpdmb_defines.vh"
module tpdmb_bank_monitor #(parameter NCORES = 4) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hwdata,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] platform_capability_reg,
   input wire branch_taken,
   input wire [3:0] branch_kind,
   input wire [NCORES-1:0] core_in_wait_idle,
   input wire [31:0] current_power_limits_r,
   input wire [31:0] turbo_ratio_caps_r,
   input wire [31:0] branch_filter_select_r,
   input wire [31:0] debug_control_r,
   input wire branch_recorded_r,
   input wire min_point_req_r
);
   reg wr_r;
   reg [9:0] idx_r;
   // Write taken in the address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_r <= 1'b0;
         idx_r <= 10'h000;
      end else begin
         wr_r <= hsel & hready & htrans[1] & hwrite;
         idx_r <= haddr[11:2];
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   chk_cpl_write: assert property (
      wr_r && idx_r == `TPDMB_IDX_CPL |=>
      current_power_limits_r == $past(hwdata)) else $error("cpl write");
   chk_trc_write: assert property (
      wr_r && idx_r == `TPDMB_IDX_TRC && platform_capability_reg[28] |=>
      turbo_ratio_caps_r == $past(hwdata)) else $error("trc write");
   chk_trc_locked: assert property (
      !platform_capability_reg[28] |=> $stable(turbo_ratio_caps_r))
      else $error("trc changed while locked");
   chk_fsel_write: assert property (
      wr_r && idx_r == `TPDMB_IDX_FSEL |=> branch_filter_select_r ==
      ($past(hwdata) & `TPDMB_FSEL_MASK)) else $error("fsel write");
   chk_dbg_write: assert property (
      wr_r && idx_r == `TPDMB_IDX_DBG |=> debug_control_r ==
      ($past(hwdata) & `TPDMB_DBG_MASK)) else $error("dbg write");
   chk_branch_kept: assert property (
      branch_taken && !branch_filter_select_r[branch_kind] |=>
      branch_recorded_r) else $error("branch not kept");
   chk_branch_dropped: assert property (
      !branch_taken || branch_filter_select_r[branch_kind] |=>
      !branch_recorded_r) else $error("branch wrongly kept");
   chk_min_point: assert property (
      !(&core_in_wait_idle) |=> !min_point_req_r)
      else $error("min point without all idle");
   chk_bus_ready: assert property (
      hreadyout) else $error("wait state inserted");
   chk_bus_okay: assert property (
      !hresp) else $error("error response");
endmodule // tpdmb_bank_monitor
bind tpdmb_bank tpdmb_bank_monitor #(.NCORES(NCORES)) u_mon (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
   .hreadyout(hreadyout), .hresp(hresp),
   .platform_capability_reg(platform_capability_reg),
   .branch_taken(branch_taken), .branch_kind(branch_kind),
   .core_in_wait_idle(core_in_wait_idle),
   .current_power_limits_r(current_power_limits_r),
   .turbo_ratio_caps_r(turbo_ratio_caps_r),
   .branch_filter_select_r(branch_filter_select_r),
   .debug_control_r(debug_control_r),
   .branch_recorded_r(branch_recorded_r),
   .min_point_req_r(min_point_req_r));

// >>> verif/tpdmb_bank_tb.sv
// Register access test bench of the debug register bank
`timescale 1ns/100ps
`include "tpdmb_defines.vh"
module tpdmb_bank_tb;
   reg hclk = 1'b0;
   reg hresetn = 1'b0;
   reg [31:0] haddr = 32'h0, hwdata = 32'h0, pcap = 32'h0, bfrom = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0, btk = 1'b0, exc = 1'b0;
   reg [3:0] bkind = 4'h0, idle = 4'h0;
   wire [31:0] hrdata, cpl, trc;
   wire hready, minpt;
   integer n_errors = 0, check_count = 0, i;
   reg [31:0] q;
   reg [9:0] ix [0:9] = '{`TPDMB_IDX_CPL, `TPDMB_IDX_TRC, `TPDMB_IDX_FSEL,
      `TPDMB_IDX_DBG, `TPDMB_IDX_PWR, `TPDMB_IDX_TOS, `TPDMB_IDX_LSRC,
      `TPDMB_IDX_LDST, `TPDMB_IDX_SMBASE, `TPDMB_IDX_MTB0};
   reg [31:0] mk [0:9] = '{`TPDMB_CPL_MASK, 32'h0, `TPDMB_FSEL_MASK,
      `TPDMB_DBG_MASK, `TPDMB_PWR_MASK, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   always #4 hclk = ~hclk;
   tpdmb_bank uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hready), .hresp(), .platform_capability_reg(pcap),
      .branch_taken(btk), .branch_kind(bkind), .branch_from(bfrom),
      .branch_to(~bfrom), .exception_event(exc), .core_in_wait_idle(idle),
      .current_power_limits_r(cpl), .turbo_ratio_caps_r(trc),
      .branch_filter_select_r(), .debug_control_r(),
      .branch_recorded_r(), .min_point_req_r(minpt));
   task end_of_test;
      begin
         if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %0t seen %h exp %h", $time, seen, exp);
         end
      end
   endtask
   task waitrdy;
      integer n;
      begin
         n = 0;
         @(posedge hclk);
         while (hready !== 1'b1 && n < 40) begin
            n = n + 1;
            @(posedge hclk);
         end
         if (n == 40) begin
            n_errors = n_errors + 1;
            end_of_test;
         end
      end
   endtask
   // One AHB single word; read data lands in q
   task xfer(input [9:0] idx, input w, input [31:0] d);
      begin
         haddr <= {20'h0, idx, 2'h0};
         hwrite <= w;
         htrans <= 2'h2;
         waitrdy;
         htrans <= 2'h0;
         hwdata <= d;
         waitrdy;
         q = hrdata;
      end
   endtask
   // Branch when b is one, otherwise an exception
   task pulse(input b, input [3:0] k, input [31:0] f);
      begin
         btk <= b;
         exc <= !b;
         bkind <= k;
         bfrom <= f;
         @(posedge hclk);
         btk <= 1'b0;
         exc <= 1'b0;
         @(posedge hclk);
      end
   endtask
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      for (i = 0; i < 10; i = i + 1) begin
         xfer(ix[i], 1'b0, 32'h0);
         chk(q, 32'h0);
         xfer(ix[i], 1'b1, 32'hffffffff);
         xfer(ix[i], 1'b0, 32'h0);
         chk(q, mk[i]);
      end
      xfer(`TPDMB_IDX_CPL, 1'b1, 32'h40058003);
      xfer(`TPDMB_IDX_CPL, 1'b0, 32'h0);
      chk(q, 32'h40058003);
      chk(cpl, 32'h40058003);
      pcap <= 32'h10000000;
      xfer(`TPDMB_IDX_TRC, 1'b1, 32'h44332211);
      xfer(`TPDMB_IDX_TRC, 1'b0, 32'h0);
      chk(q, 32'h44332211);
      chk({24'h0, trc[15:8]}, 32'h22);
      chk({24'h0, trc[31:24]}, 32'h44);
      xfer(`TPDMB_IDX_FSEL, 1'b1, 32'h2);
      pulse(1'b1, 4'h0, 32'h1000);
      pulse(1'b1, 4'h1, 32'h2000);
      pulse(1'b0, 4'h0, 32'h0);
      pulse(1'b1, 4'h0, 32'h3000);
      xfer(`TPDMB_IDX_TOS, 1'b0, 32'h0);
      chk(q, 32'h2);
      xfer(`TPDMB_IDX_LSRC, 1'b0, 32'h0);
      chk(q, 32'h1000);
      xfer(`TPDMB_IDX_LDST, 1'b0, 32'h0);
      chk(q, ~32'h1000);
      idle <= 4'hf;
      repeat (3) @(posedge hclk);
      chk({31'h0, minpt}, 32'h1);
      idle <= 4'h7;
      repeat (3) @(posedge hclk);
      chk({31'h0, minpt}, 32'h0);
      xfer(`TPDMB_IDX_PWR, 1'b1, 32'h0);
      idle <= 4'hf;
      repeat (3) @(posedge hclk);
      chk({31'h0, minpt}, 32'h0);
      end_of_test;
   end
endmodule // tpdmb_bank_tb
